// [design/kslm_regs.svh]
// Register offsets, field positions, reset values and timing counts of the matrix scanner
// Functional notes
// (RULE1) Phase high: both column groups read keys
// (RULE2) Phase low: read switches, drive LEDs
// (RULE3) Three row bits select eight rows
// (RULE4) Row value also selects slider channel
// (RULE5) Fourth row bit: 176 switches, 16 sliders
// (RULE6) Break columns give first key contact
// (RULE7) First contact polarity configurable by wiring
// (RULE8) Make columns give second contact, key-on
// (RULE9) Second contact diode polarity configurable
// (RULE10) Switch phase stores break columns per row
// (RULE11) Switch phase drives row's LED pattern
// (RULE12) Slider voltage converted as row reading
// (RULE13) Fourth row bit replaces pin zero function
// (RULE14) Cycle rows, settle before sampling
// (RULE15) Each row gets both phases; in row mode rows 8 to 15 get the switch phase only
`ifndef KSLM_REGS_SVH
`define KSLM_REGS_SVH

// Register byte offsets
`define KSLM_CTRL_OFS 12'h000
`define KSLM_GPIO_OFS 12'h004
`define KSLM_STAT_OFS 12'h008
`define KSLM_KBRK_OFS 12'h040
`define KSLM_KMAK_OFS 12'h060
`define KSLM_SWIT_OFS 12'h080
`define KSLM_LED_OFS 12'h0C0
`define KSLM_SLID_OFS 12'h100

// Control fields
`define KSLM_CTRL_EN 0
`define KSLM_CTRL_ROW4 1
`define KSLM_CTRL_BRK_NO 2
`define KSLM_CTRL_BRK_CC 3
`define KSLM_CTRL_MAK_CC 4
`define KSLM_CTRL_RST 5'h00

// General pin zero fields
`define KSLM_GPIO_OUT 0
`define KSLM_GPIO_DRV 1
`define KSLM_GPIO_IN 2
`define KSLM_GPIO_RST 2'h0

// Status fields
`define KSLM_STAT_ROW 0
`define KSLM_STAT_PHASE 4
`define KSLM_STAT_BUSY 5
`define KSLM_STAT_FRAME 8

// Row settle time
`define KSLM_CLK_NS 50
`define KSLM_SETTLE_NS 1000
`define KSLM_SETTLE_CYC ((`KSLM_SETTLE_NS + `KSLM_CLK_NS - 1) / `KSLM_CLK_NS)

`endif

// [design/kslm_pkg.sv]
// Types shared by the matrix scanner files
package kslm_pkg;
  typedef logic [10:0] kslm_col_t;
  typedef logic [7:0] kslm_slider_t;
  // Gray coded along the scan path of the lower eight rows
  typedef enum logic [2:0] {
    KSLM_IDLE = 3'h0,
    KSLM_KEY_WAIT = 3'h1,
    KSLM_KEY_SAMP = 3'h3,
    KSLM_SW_WAIT = 3'h2,
    KSLM_SW_SAMP = 3'h6,
    KSLM_CONV = 3'h7,
    KSLM_NEXT = 3'h5
  } kslm_state_t;
endpackage : kslm_pkg

// [design/kslm_settle_timer.sv]
// Row settle timer: one-cycle done pulse a fixed time after start
`timescale 1ns/1ns
`include "kslm_regs.svh"
module kslm_settle_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  output logic done
);
  localparam logic [7:0] SETTLE_CYC = 8'(`KSLM_SETTLE_CYC);

  logic [7:0] cnt_q;
  logic busy_q;
  logic done_q;

  // Countdown; a restart while busy reloads the full time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q <= SETTLE_CYC;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign done = done_q;
endmodule : kslm_settle_timer

// [design/kslm_scanner.sv]
// Key, switch, LED and slider matrix scanner with APB register access
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "kslm_regs.svh"
module kslm_scanner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Matrix rows and phase
  output logic [2:0] row_select_bus,
  output logic matrix_phase_select,
  // Matrix columns
  input wire logic [10:0] break_columns,
  input wire logic [10:0] make_columns_in,
  output logic [10:0] make_columns_out,
  output logic make_columns_oe_n,
  // General pin zero, carries the extra row bit in row mode
  input wire logic general_pin_zero_in,
  output logic general_pin_zero_out,
  output logic general_pin_zero_oe_n,
  // Slider converter start, done and data
  output logic slider_conv_start,
  input wire logic slider_conv_done,
  input wire logic [7:0] slider_conv_data
);

  // Apply contact wiring polarity: result is 1 for an active contact
  function automatic kslm_pkg::kslm_col_t kslm_polar(input kslm_pkg::kslm_col_t raw, input logic inv);
    kslm_polar = inv ? ~raw : raw;
  endfunction : kslm_polar

  // Index of a word inside a register bank, or all ones when outside it
  function automatic logic [4:0] kslm_bank(input logic [11:0] addr, input logic [11:0] base,
                                           input logic [4:0] words);
    logic [11:0] diff;
    diff = addr - base;
    if (addr >= base && diff[11:2] < {5'h00, words} && diff[1:0] == 2'h0) begin
      kslm_bank = diff[6:2];
    end else begin
      kslm_bank = 5'h1F;
    end
  endfunction : kslm_bank

  // Software state
  logic [4:0] ctrl_q;
  logic [1:0] gpio_q;
  kslm_pkg::kslm_col_t led_q [8];

  // Scan results
  kslm_pkg::kslm_col_t kbrk_q [8];
  kslm_pkg::kslm_col_t kmak_q [8];
  kslm_pkg::kslm_col_t swit_q [16];
  kslm_pkg::kslm_slider_t slid_q [16];

  // Scanner state
  kslm_pkg::kslm_state_t state_q;
  logic [3:0] row_q;
  logic phase_q;
  logic [7:0] frame_q;
  logic settle_start_q;
  logic conv_start_q;
  kslm_pkg::kslm_col_t make_out_q;
  logic make_oe_n_q;
  logic pin_out_q;
  logic pin_oe_n_q;

  // Bus answer
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic err_d;

  logic settle_done;
  logic wr_en;
  logic [3:0] last_row;
  logic [3:0] next_row;
  logic brk_inv;
  logic mak_inv;

  // One shared timer serves both phases, since they never settle at once
  kslm_settle_timer u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .start(settle_start_q),
    .done(settle_done)
  );

  // Write takes effect at the completing edge of the access phase
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
  // (RULE5) sixteen rows in row mode
  assign last_row = ctrl_q[`KSLM_CTRL_ROW4] ? 4'hF : 4'h7;
  // Compare with >= so leaving row mode inside the upper rows wraps at once
  assign next_row = (row_q >= last_row) ? 4'h0 : row_q + 4'h1;
  // (RULE7) normally open and diode direction
  assign brk_inv = ctrl_q[`KSLM_CTRL_BRK_NO] ^ ctrl_q[`KSLM_CTRL_BRK_CC];
  // (RULE9) make diode direction
  assign mak_inv = ctrl_q[`KSLM_CTRL_MAK_CC];

  // Read decode; unmapped offsets answer with an error and zero data
  always_comb begin
    logic [4:0] ix;
    ix = 5'h1F;
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == `KSLM_CTRL_OFS) begin
      rd_d[4:0] = ctrl_q;
    end else if (paddr == `KSLM_GPIO_OFS) begin
      rd_d[1:0] = gpio_q;
      rd_d[`KSLM_GPIO_IN] = general_pin_zero_in;
    end else if (paddr == `KSLM_STAT_OFS) begin
      rd_d[`KSLM_STAT_ROW +: 4] = row_q;
      rd_d[`KSLM_STAT_PHASE] = phase_q;
      rd_d[`KSLM_STAT_BUSY] = (state_q != kslm_pkg::KSLM_IDLE);
      rd_d[`KSLM_STAT_FRAME +: 8] = frame_q;
    end else if (kslm_bank(paddr, `KSLM_KBRK_OFS, 5'h08) != 5'h1F) begin
      ix = kslm_bank(paddr, `KSLM_KBRK_OFS, 5'h08);
      rd_d[10:0] = kbrk_q[ix[2:0]];
    end else if (kslm_bank(paddr, `KSLM_KMAK_OFS, 5'h08) != 5'h1F) begin
      ix = kslm_bank(paddr, `KSLM_KMAK_OFS, 5'h08);
      rd_d[10:0] = kmak_q[ix[2:0]];
    end else if (kslm_bank(paddr, `KSLM_SWIT_OFS, 5'h10) != 5'h1F) begin
      ix = kslm_bank(paddr, `KSLM_SWIT_OFS, 5'h10);
      rd_d[10:0] = swit_q[ix[3:0]];
    end else if (kslm_bank(paddr, `KSLM_LED_OFS, 5'h08) != 5'h1F) begin
      ix = kslm_bank(paddr, `KSLM_LED_OFS, 5'h08);
      rd_d[10:0] = led_q[ix[2:0]];
    end else if (kslm_bank(paddr, `KSLM_SLID_OFS, 5'h10) != 5'h1F) begin
      ix = kslm_bank(paddr, `KSLM_SLID_OFS, 5'h10);
      rd_d[7:0] = slid_q[ix[3:0]];
    end else begin
      err_d = 1'b1;
    end
  end

  // APB answer: captured in the setup cycle, so the access phase has no wait
  // Writes read back zero so stale read data never shows in a write access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      pready_q <= 1'b1;
      pslverr_q <= err_d;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Software-written control and LED pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `KSLM_CTRL_RST;
      gpio_q <= `KSLM_GPIO_RST;
      for (int i = 0; i < 8; i++) begin
        led_q[i] <= 11'h000;
      end
    end else if (wr_en) begin
      if (paddr == `KSLM_CTRL_OFS) begin
        ctrl_q <= pwdata[4:0];
      end
      if (paddr == `KSLM_GPIO_OFS) begin
        gpio_q <= pwdata[1:0];
      end
      if (kslm_bank(paddr, `KSLM_LED_OFS, 5'h08) != 5'h1F) begin
        led_q[paddr[4:2]] <= pwdata[10:0];
      end
    end
  end

  // Scan sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= kslm_pkg::KSLM_IDLE;
      row_q <= 4'h0;
      phase_q <= 1'b0;
      frame_q <= 8'h00;
      settle_start_q <= 1'b0;
      conv_start_q <= 1'b0;
      make_out_q <= 11'h000;
      make_oe_n_q <= 1'b1;
    end else begin
      settle_start_q <= 1'b0;
      conv_start_q <= 1'b0;
      case (state_q)
        kslm_pkg::KSLM_IDLE: begin
          make_oe_n_q <= 1'b1;
          if (ctrl_q[`KSLM_CTRL_EN]) begin
            // (RULE1) keyboard phase, columns are inputs
            row_q <= 4'h0;
            phase_q <= 1'b1;
            settle_start_q <= 1'b1;
            state_q <= kslm_pkg::KSLM_KEY_WAIT;
          end
        end
        // (RULE14) wait for row settle
        kslm_pkg::KSLM_KEY_WAIT: begin
          if (settle_done) begin
            state_q <= kslm_pkg::KSLM_KEY_SAMP;
          end
        end
        kslm_pkg::KSLM_KEY_SAMP: begin
          // (RULE15) switch to LED phase
          phase_q <= 1'b0;
          // (RULE11) drive row LED pattern
          make_out_q <= led_q[row_q[2:0]];
          make_oe_n_q <= 1'b0;
          settle_start_q <= 1'b1;
          state_q <= kslm_pkg::KSLM_SW_WAIT;
        end
        kslm_pkg::KSLM_SW_WAIT: begin
          if (settle_done) begin
            state_q <= kslm_pkg::KSLM_SW_SAMP;
          end
        end
        kslm_pkg::KSLM_SW_SAMP: begin
          // (RULE12) convert the selected slider
          conv_start_q <= 1'b1;
          state_q <= kslm_pkg::KSLM_CONV;
        end
        // No timeout: a converter that never answers holds the scan on this row
        kslm_pkg::KSLM_CONV: begin
          if (slider_conv_done) begin
            state_q <= kslm_pkg::KSLM_NEXT;
          end
        end
        kslm_pkg::KSLM_NEXT: begin
          if (!ctrl_q[`KSLM_CTRL_EN]) begin
            make_oe_n_q <= 1'b1;
            phase_q <= 1'b0;
            state_q <= kslm_pkg::KSLM_IDLE;
          end else begin
            // (RULE14) step through enabled rows
            row_q <= next_row;
            if (next_row == 4'h0) begin
              frame_q <= frame_q + 8'h01;
            end
            settle_start_q <= 1'b1;
            if (!next_row[3]) begin
              // (RULE15) keyboard phase first
              phase_q <= 1'b1;
              make_oe_n_q <= 1'b1;
              state_q <= kslm_pkg::KSLM_KEY_WAIT;
            end else begin
              // Upper rows carry switches and sliders only, no keys or LEDs
              phase_q <= 1'b0;
              make_out_q <= 11'h000;
              make_oe_n_q <= 1'b0;
              state_q <= kslm_pkg::KSLM_SW_WAIT;
            end
          end
        end
        default: begin
          state_q <= kslm_pkg::KSLM_IDLE;
        end
      endcase
    end
  end

  // Key contact capture, lower eight rows only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        kbrk_q[i] <= 11'h000;
        kmak_q[i] <= 11'h000;
      end
    end else if (state_q == kslm_pkg::KSLM_KEY_SAMP) begin
      // (RULE6) first contact from break columns
      kbrk_q[row_q[2:0]] <= kslm_polar(break_columns, brk_inv);
      // (RULE8) key-on from make columns
      kmak_q[row_q[2:0]] <= kslm_polar(make_columns_in, mak_inv);
    end
  end

  // Switch capture for every enabled row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        swit_q[i] <= 11'h000;
      end
    end else if (state_q == kslm_pkg::KSLM_SW_SAMP) begin
      // (RULE10) store switches per row
      swit_q[row_q] <= break_columns;
    end
  end

  // Slider readings, indexed by the row that chose the channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        slid_q[i] <= 8'h00;
      end
    end else if (state_q == kslm_pkg::KSLM_CONV && slider_conv_done) begin
      // (RULE12) store as row's slider
      slid_q[row_q] <= slider_conv_data;
    end
  end

  // Pin zero: row bit in row mode, else plain general-purpose pin
  // The row bit follows row_q one cycle late; the settle time covers it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else if (ctrl_q[`KSLM_CTRL_ROW4]) begin
      // (RULE13) alternate function replaces pin
      pin_out_q <= row_q[3];
      pin_oe_n_q <= 1'b0;
    end else begin
      pin_out_q <= gpio_q[`KSLM_GPIO_OUT];
      pin_oe_n_q <= ~gpio_q[`KSLM_GPIO_DRV];
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // (RULE3) three row bits to the matrix
  // (RULE4) shared by keys, switches, sliders
  assign row_select_bus = row_q[2:0];
  // (RULE2) phase low drives LEDs
  assign matrix_phase_select = phase_q;
  assign make_columns_out = make_out_q;
  assign make_columns_oe_n = make_oe_n_q;
  assign general_pin_zero_out = pin_out_q;
  assign general_pin_zero_oe_n = pin_oe_n_q;
  assign slider_conv_start = conv_start_q;

endmodule : kslm_scanner

// [testbench/kslm_checker.sv]
// Port assertions for the matrix scanner
`timescale 1ns/1ns
module kslm_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Matrix side
  input wire logic [2:0] row_select_bus,
  input wire logic matrix_phase_select,
  input wire logic make_columns_oe_n,
  input wire logic slider_conv_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] row_q;
  logic ph_q;
  logic [5:0] calm_q;
  // Cycles since row or phase last moved, saturating so it never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= 3'h0;
      ph_q <= 1'b0;
      calm_q <= 6'h00;
    end else begin
      row_q <= row_select_bus;
      ph_q <= matrix_phase_select;
      if (row_q != row_select_bus || ph_q != matrix_phase_select) calm_q <= 6'h00;
      else if (calm_q != 6'h3F) calm_q <= calm_q + 6'h01;
    end
  end
  reset_idle_a: assert property (disable iff (1'b0) !presetn |-> make_columns_oe_n && !slider_conv_start)
    else $error("outputs active in reset");
  ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  err_map_a: assert property (pready && paddr == 12'hFF0 |-> pslverr) else $error("unmapped not refused");
  key_in_a: assert property (matrix_phase_select |-> make_columns_oe_n)
    else $error("make lines driven in key phase");
  led_out_a: assert property (!make_columns_oe_n |-> !matrix_phase_select)
    else $error("LED drive outside switch phase");
  settle_a: assert property (slider_conv_start |-> calm_q >= 6'h14)
    else $error("conversion before settle");
  conv_pulse_a: assert property (slider_conv_start |=> !slider_conv_start) else $error("start not a pulse");
  conv_sw_a: assert property (slider_conv_start |-> !matrix_phase_select)
    else $error("conversion in key phase");
  conv_hold_a: assert property (slider_conv_start |=> $stable(row_select_bus) [*3])
    else $error("row moved during conversion");
  both_phase_a: assert property ($fell(matrix_phase_select) |-> $stable(row_select_bus))
    else $error("row moved between phases");
  key_hold_a: assert property ($rose(matrix_phase_select) |=> matrix_phase_select [*8])
    else $error("key phase too short");
endmodule : kslm_checker

// [testbench/kslm_matrix_model.sv]
// Passive key, switch, LED and slider hardware behind the scanner
`timescale 1ns/1ns
module kslm_matrix_model (
  // Scanner outputs
  input wire logic pclk,
  input wire logic [2:0] row_select_bus,
  input wire logic matrix_phase_select,
  input wire logic [10:0] make_columns_out,
  input wire logic make_columns_oe_n,
  input wire logic general_pin_zero_out,
  input wire logic general_pin_zero_oe_n,
  input wire logic slider_conv_start,
  // Scanner inputs
  output logic [10:0] break_columns,
  output logic [10:0] make_columns_in,
  output logic general_pin_zero_in,
  output logic slider_conv_done,
  output logic [7:0] slider_conv_data
);
  logic [3:0] row;
  logic [3:0] conv_row = 4'h0;
  logic [2:0] wait_q = 3'h0;
  logic [10:0] led_seen [16];
  // pin zero adds the top row bit when driven
  assign row = {~general_pin_zero_oe_n & general_pin_zero_out, row_select_bus};
  // Pull-up holds pin zero high when released
  assign general_pin_zero_in = general_pin_zero_oe_n ? 1'b1 : general_pin_zero_out;
  assign break_columns = matrix_phase_select ? (11'h155 ^ {7'h00, row}) : (11'h0F0 ^ {row, 7'h00});
  // second contacts; driven LED data wins on the wire
  assign make_columns_in = !make_columns_oe_n ? make_columns_out :
    matrix_phase_select ? (11'h2AA ^ {7'h00, row}) : ~(11'h2AA ^ {7'h00, row});
  // converter answers four cycles after start for the row then selected
  always @(posedge pclk) begin
    slider_conv_done <= 1'b0;
    if (slider_conv_start) begin
      conv_row <= row;
      wait_q <= 3'h4;
      led_seen[row] <= make_columns_out;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
      slider_conv_done <= (wait_q == 3'h1);
    end
  end
  // Data is junk outside the done pulse
  assign slider_conv_data = slider_conv_done ? (8'h30 + {4'h0, conv_row}) : ~(8'h30 + {4'h0, conv_row});
endmodule : kslm_matrix_model

// [testbench/tb.sv]
// Self-checking bench for the matrix scanner
`timescale 1ns/1ns
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, matrix_phase_select, make_columns_oe_n;
  logic [2:0] row_select_bus;
  logic [10:0] break_columns, make_columns_in, make_columns_out;
  logic general_pin_zero_in, general_pin_zero_out, general_pin_zero_oe_n;
  logic slider_conv_start, slider_conv_done;
  logic [7:0] slider_conv_data;
  logic [4:0] cfgs [4] = '{5'h01, 5'h05, 5'h0D, 5'h19};
  logic [10:0] ib, im;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // 20 MHz clock
  always #25 pclk = ~pclk;
  kslm_scanner DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .row_select_bus, .matrix_phase_select, .break_columns, .make_columns_in, .make_columns_out,
    .make_columns_oe_n, .general_pin_zero_in, .general_pin_zero_out, .general_pin_zero_oe_n,
    .slider_conv_start, .slider_conv_done, .slider_conv_data);
  kslm_matrix_model u_model (.pclk, .row_select_bus, .matrix_phase_select, .make_columns_out,
    .make_columns_oe_n, .general_pin_zero_out, .general_pin_zero_oe_n, .slider_conv_start,
    .break_columns, .make_columns_in, .general_pin_zero_in, .slider_conv_done, .slider_conv_data);
  task end_sim;
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high or 20 cycles pass
  task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask : xfer
  task rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk
  // Wait for two frame wraps so one whole frame ran under the current setup
  task frames;
    logic [7:0] f0;
    int k;
    xfer(1'b0, 12'h008, 32'h0);
    f0 = rd[15:8];
    k = 0;
    while (k < 400 && rd[15:8] - f0 < 8'h02) begin
      repeat (10) @(posedge pclk);
      xfer(1'b0, 12'h008, 32'h0);
      k++;
    end
    chk("frame wrap", 32'h1, {31'h0, k < 400});
  endtask : frames
  // Hang guard, far above the expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    // Falling edge at time zero puts the design in reset before the first clock
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", 12'h000, 32'h0);
    rchk("gpio", 12'h004, 32'h4);
    rchk("status", 12'h008, 32'h0);
    for (int r = 0; r < 8; r++) xfer(1'b1, 12'(12'h0C0 + 4 * r), 32'(11'h501 + r * 7));
    // Four contact wiring settings, each over one full frame
    foreach (cfgs[c]) begin
      ib = (cfgs[c][2] ^ cfgs[c][3]) ? 11'h7FF : 11'h000;
      im = cfgs[c][4] ? 11'h7FF : 11'h000;
      xfer(1'b1, 12'h000, {27'h0, cfgs[c]});
      frames;
      for (int r = 0; r < 8; r++) begin
        rchk("key break", 12'(12'h040 + 4 * r), 32'(ib ^ 11'h155 ^ r));
        rchk("key make", 12'(12'h060 + 4 * r), 32'(im ^ 11'h2AA ^ r));
        rchk("switch", 12'(12'h080 + 4 * r), 32'(11'h0F0 ^ (r << 7)));
        rchk("slider", 12'(12'h100 + 4 * r), 32'(8'h30 + r));
        chk("led", 32'(11'h501 + r * 7), {21'h0, u_model.led_seen[r]});
      end
    end
    xfer(1'b0, 12'hFF0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // Pin zero as plain output before it becomes a row bit
    xfer(1'b1, 12'h004, 32'h3);
    rchk("gpio high", 12'h004, 32'h7);
    xfer(1'b1, 12'h004, 32'h2);
    rchk("gpio low", 12'h004, 32'h2);
    xfer(1'b1, 12'h004, 32'h0);
    xfer(1'b1, 12'h000, 32'h3);
    frames;
    for (int r = 8; r < 16; r++) begin
      rchk("upper switch", 12'(12'h080 + 4 * r), 32'(11'h0F0 ^ (r << 7)));
      rchk("upper slider", 12'(12'h100 + 4 * r), 32'(8'h30 + r));
    end
    xfer(1'b0, 12'h008, 32'h0);
    chk("busy", 32'h1, {31'h0, rd[5]});
    // Clearing enable stops at the end of the row and releases the LED lines
    xfer(1'b1, 12'h000, 32'h0);
    repeat (100) @(posedge pclk);
    xfer(1'b0, 12'h008, 32'h0);
    chk("idle status", 32'h0, {30'h0, rd[5:4]});
    chk("led released", 32'h1, {31'h0, make_columns_oe_n});
    end_sim;
  end
endmodule : tb
bind kslm_scanner kslm_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .row_select_bus, .matrix_phase_select, .make_columns_oe_n, .slider_conv_start);
